// ### logic/aeq_pkg.sv
// constants and types for the adaptive equalizer control block
// assumes one 20 MHz device clock and a byte-wide register port
// Function
// RULE_01: any set select bit enables error counting
// RULE_02: errors accumulate over half relock period
// RULE_03: count above limit moves to next setting
// RULE_04: single step judges lock after half period
// RULE_05: two step: any second-half error moves on
// RULE_06: loop order bit picks inner and outer
// RULE_07: sample filter adapts only when enabled
// RULE_08: software never writes zero error limit
// RULE_09: capability bit four gates encoder crc flag
// RULE_10: software sets flag, clears encoder crc disable
// RULE_11: capability copy chosen by port select register
// RULE_12: offsets 0x44 to 0x49 read zero
// RULE_13: sample filter stays between lower and upper
// RULE_14: accumulator cleared per window and setting
package aeq_pkg;
    localparam int CLK_HZ = 20000000;
    localparam logic [7:0] ADDR_CTL    = 8'h42;
    localparam logic [7:0] ADDR_THOLD  = 8'h43;
    localparam logic [7:0] ADDR_RSV_LO = 8'h44;
    localparam logic [7:0] ADDR_RSV_HI = 8'h49;
    localparam logic [7:0] ADDR_CAP    = 8'h4a;
    localparam logic [7:0] ADDR_PSEL   = 8'h4c;
    localparam logic [2:0] ERR_SEL_RST = 3'h7;
    localparam logic [7:0] THOLD_RST   = 8'h01;
    localparam logic [7:0] CAP_RST     = 8'h00;
    localparam int CAP_CRC_BIT = 4;
    localparam int PSEL_RD_BIT = 4;
    localparam logic [3:0] EQ_MAX = 4'hf;
    localparam logic [3:0] SF_MAX = 4'he;
    localparam logic [3:0] SF_MID = 4'h7;
    localparam logic [7:0] CNT_MAX = 8'hff;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_WAIT    = 2'h1,
        ST_CHECK   = 2'h3,
        ST_MONITOR = 2'h2
    } aeq_state_t;
endpackage : aeq_pkg

// ### logic/acc_if.sv
// carrier between the adaption control and its error accumulator
// assumes both ends on the device clock
`timescale 1ns/1ns
`default_nettype none
interface acc_if;
    logic       clear;
    logic       inc;
    logic [7:0] count;
    modport ctrl (output clear, output inc, input count);
    modport acc  (input clear, input inc, output count);
endinterface : acc_if
`default_nettype wire

// ### logic/err_accum.sv
// saturating error accumulator for one window
// assumes clear and inc come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module err_accum (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    acc_if.acc        acc
);
    import aeq_pkg::*;
    typedef struct packed {
        logic [7:0] cnt;
    } acc_state_t;
    acc_state_t s_reg;
    acc_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (acc.clear) begin
            s_next.cnt = {7'h00, acc.inc}; // RULE_14
        end else if (acc.inc && s_reg.cnt != CNT_MAX) begin
            s_next.cnt = s_reg.cnt + 8'h01; // RULE_02
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign acc.count = s_reg.cnt;

    ////////////////////////////////////////////////////////////////////
    AST_ACC_CLEAR: assert property (@(posedge mclk_in) disable iff (rst_in)
        acc.clear |=> acc.count == {7'h00, $past(acc.inc)}) // RULE_14
        else $error("accumulator not cleared");
    AST_ACC_INC: assert property (@(posedge mclk_in) disable iff (rst_in)
        (acc.inc && !acc.clear && acc.count != CNT_MAX)
        |=> acc.count == $past(acc.count) + 8'h01) // RULE_02
        else $error("error not counted");
endmodule : err_accum
`default_nettype wire

// ### logic/adaptive_eq_control.sv
// adaption control, error gating and paged registers of the receiver
// assumes link error strobes and register strobes on mclk_in
`timescale 1ns/1ns
`default_nettype none
module adaptive_eq_control (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        adapt_enable_in,
    input  wire logic [15:0] relock_timer_period_in,
    input  wire logic [3:0]  sample_filter_lower_in,
    input  wire logic [3:0]  sample_filter_upper_in,
    input  wire logic        lock_in,
    input  wire logic        clk_err_in,
    input  wire logic        enc_err_in,
    input  wire logic        par_err_in,
    input  wire logic [1:0]  crc_err_in,
    output logic [1:0]       crc_err_flag_out,
    output logic [3:0]       eq_setting_out,
    output logic [3:0]       sf_setting_out,
    output logic             adapt_locked_out,
    output aeq_pkg::aeq_state_t adapt_state_out
);
    import aeq_pkg::*;

    typedef struct packed {
        logic [2:0]      err_sel;
        logic            rsv3;
        logic            two_step;
        logic            outer;
        logic            sf_en;
        logic [7:0]      thold;
        logic [1:0][7:0] cap;
        logic            rd_port;
        logic [1:0]      wr_en;
        logic [7:0]      rdata;
        aeq_state_t      st;
        logic [15:0]     timer;
        logic [3:0]      eq;
        logic [3:0]      sf;
        logic [1:0]      crc_flag;
        logic            locked;
    } ctl_state_t;

    ctl_state_t s_reg;
    ctl_state_t s_next;
    acc_if      acc ();
    logic [15:0] half;
    logic        half_done;
    logic        err_hit;

    err_accum u_accum (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .acc     (acc)
    );

    function automatic logic [7:0] step(input logic [3:0] eq,
            input logic [3:0] sf, input logic sf_en, input logic outer,
            input logic [3:0] lo, input logic [3:0] hi);
        logic [3:0] e;
        logic [3:0] f;
        e = eq;
        f = sf;
        if (!sf_en) begin
            e = eq + 4'h1; // RULE_07
        end else if (!outer) begin
            e = eq + 4'h1; // RULE_06
            if (eq == EQ_MAX) begin
                f = (sf >= hi || sf >= SF_MAX) ? lo : sf + 4'h1; // RULE_13
            end
        end else begin
            if (sf >= hi || sf >= SF_MAX) begin // RULE_13
                f = lo;
                e = eq + 4'h1; // RULE_06
            end else begin
                f = sf + 4'h1;
            end
        end
        return {e, f};
    endfunction : step

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        half = {1'b0, relock_timer_period_in[15:1]}; // RULE_02
        if (half == 16'h0000) begin
            half = 16'h0001;
        end
        half_done = (s_reg.timer >= half - 16'h0001);
        err_hit = |(s_reg.err_sel & {clk_err_in, enc_err_in, par_err_in});
    end

    always_comb begin
        s_next = s_reg;
        acc.clear = 1'b0;
        acc.inc = err_hit && s_reg.st != ST_IDLE; // RULE_01
        // register port
        if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_CTL: begin
                    s_next.err_sel  = reg_wdata_in[6:4];
                    s_next.rsv3     = reg_wdata_in[3];
                    s_next.two_step = reg_wdata_in[2];
                    s_next.outer    = reg_wdata_in[1];
                    s_next.sf_en    = reg_wdata_in[0];
                end
                ADDR_THOLD: s_next.thold = reg_wdata_in;
                ADDR_CAP: begin
                    for (int p = 0; p < 2; p++) begin
                        if (s_reg.wr_en[p]) begin
                            s_next.cap[p] = reg_wdata_in; // RULE_11
                        end
                    end
                end
                ADDR_PSEL: begin
                    s_next.rd_port = reg_wdata_in[PSEL_RD_BIT];
                    s_next.wr_en   = reg_wdata_in[1:0];
                end
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_CTL: s_next.rdata = {1'b0, s_reg.err_sel, s_reg.rsv3,
                    s_reg.two_step, s_reg.outer, s_reg.sf_en};
                ADDR_THOLD: s_next.rdata = s_reg.thold;
                ADDR_CAP: s_next.rdata = s_reg.cap[s_reg.rd_port]; // RULE_11
                ADDR_PSEL: s_next.rdata = {3'h0, s_reg.rd_port, 2'h0,
                    s_reg.wr_en};
                default: s_next.rdata = 8'h00; // RULE_12
            endcase
        end
        // encoder crc flag gating per port
        for (int p = 0; p < 2; p++) begin
            s_next.crc_flag[p] = crc_err_in[p]
                && s_reg.cap[p][CAP_CRC_BIT]; // RULE_09
        end
        // adaption sequence
        s_next.timer = s_reg.timer + 16'h0001;
        case (s_reg.st)
            ST_IDLE: begin
                s_next.timer = '0;
                acc.clear = 1'b1;
                s_next.eq = '0;
                s_next.sf = s_reg.sf_en ? sample_filter_lower_in : SF_MID;
                if (adapt_enable_in) begin
                    s_next.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (half_done) begin
                    s_next.timer = '0;
                    acc.clear = 1'b1; // RULE_14
                    if (s_reg.two_step) begin
                        s_next.st = ST_CHECK; // RULE_05
                    end else if (lock_in) begin
                        s_next.st = ST_MONITOR; // RULE_04
                    end else begin
                        {s_next.eq, s_next.sf} = step(s_reg.eq, s_reg.sf,
                            s_reg.sf_en, s_reg.outer, sample_filter_lower_in,
                            sample_filter_upper_in); // RULE_04
                        s_next.st = ST_WAIT;
                    end
                end
            end
            ST_CHECK: begin
                if (err_hit) begin
                    s_next.timer = '0;
                    acc.clear = 1'b1; // RULE_14
                    {s_next.eq, s_next.sf} = step(s_reg.eq, s_reg.sf,
                        s_reg.sf_en, s_reg.outer, sample_filter_lower_in,
                        sample_filter_upper_in); // RULE_05
                    s_next.st = ST_WAIT;
                end else if (half_done) begin
                    s_next.timer = '0;
                    acc.clear = 1'b1;
                    s_next.st = ST_MONITOR;
                end
            end
            ST_MONITOR: begin
                if (half_done) begin
                    s_next.timer = '0;
                    acc.clear = 1'b1; // RULE_14
                    if (acc.count > s_reg.thold) begin
                        {s_next.eq, s_next.sf} = step(s_reg.eq, s_reg.sf,
                            s_reg.sf_en, s_reg.outer, sample_filter_lower_in,
                            sample_filter_upper_in); // RULE_03
                        s_next.st = ST_WAIT;
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        if (!adapt_enable_in) begin
            s_next.st = ST_IDLE;
        end
        // lock indication registered with the state
        s_next.locked = (s_next.st == ST_MONITOR); // RULE_04
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg          <= '0;
            s_reg.err_sel  <= ERR_SEL_RST; // RULE_01
            s_reg.sf_en    <= 1'b1; // RULE_07
            s_reg.thold    <= THOLD_RST;
            s_reg.cap      <= {CAP_RST, CAP_RST};
            s_reg.sf       <= SF_MID;
            s_reg.st       <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_out    = s_reg.rdata;
    assign crc_err_flag_out = s_reg.crc_flag;
    assign eq_setting_out   = s_reg.eq;
    assign sf_setting_out   = s_reg.sf;
    assign adapt_locked_out = s_reg.locked;
    assign adapt_state_out  = s_reg.st;

    ////////////////////////////////////////////////////////////////////
    AST_READAPT: assert property (@(posedge mclk_in) disable iff (rst_in)
        (s_reg.st == ST_MONITOR && half_done && adapt_enable_in
        && acc.count > s_reg.thold) |=> s_reg.st == ST_WAIT) // RULE_03
        else $error("no re-adapt on excess errors");
    AST_KEEP: assert property (@(posedge mclk_in) disable iff (rst_in)
        (s_reg.st == ST_MONITOR && half_done && adapt_enable_in
        && acc.count <= s_reg.thold) |=> s_reg.st == ST_MONITOR) // RULE_03
        else $error("left monitor below limit");
    AST_ONE_STEP: assert property (@(posedge mclk_in) disable iff (rst_in)
        (s_reg.st == ST_WAIT && half_done && !s_reg.two_step && lock_in
        && adapt_enable_in) |=> s_reg.st == ST_MONITOR) // RULE_04
        else $error("lock not accepted");
    AST_TWO_STEP: assert property (@(posedge mclk_in) disable iff (rst_in)
        (s_reg.st == ST_CHECK && err_hit && adapt_enable_in)
        |=> s_reg.st == ST_WAIT && s_reg.timer == 16'h0000) // RULE_05
        else $error("second step error ignored");
    AST_SF_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
        (!s_reg.sf_en && s_reg.st != ST_IDLE) |=> $stable(s_reg.sf)) // RULE_07
        else $error("sample filter moved while disabled");
    AST_CRC_GATE: assert property (@(posedge mclk_in) disable iff (rst_in)
        crc_err_flag_out[0] |-> $past(s_reg.cap[0][CAP_CRC_BIT])) // RULE_09
        else $error("crc flag not gated");
    AST_PAGE_WR: assert property (@(posedge mclk_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == ADDR_CAP && !s_reg.wr_en[1])
        |=> $stable(s_reg.cap[1])) // RULE_11
        else $error("disabled port copy written");
    AST_RSV_ZERO: assert property (@(posedge mclk_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in >= ADDR_RSV_LO
        && reg_addr_in <= ADDR_RSV_HI) |=> reg_rdata_out == 8'h00) // RULE_12
        else $error("reserved read not zero");
    AST_SF_RANGE: assert property (@(posedge mclk_in) disable iff (rst_in)
        sf_setting_out <= SF_MAX) // RULE_13
        else $error("sample filter out of range");
    COV_READAPT: cover property (@(posedge mclk_in) disable iff (rst_in)
        s_reg.st == ST_MONITOR ##1 s_reg.st == ST_WAIT);
    COV_TWO_STEP: cover property (@(posedge mclk_in) disable iff (rst_in)
        s_reg.st == ST_CHECK ##1 s_reg.st == ST_MONITOR);
    COV_CRC: cover property (@(posedge mclk_in) disable iff (rst_in)
        crc_err_flag_out[1]);
endmodule : adaptive_eq_control
`default_nettype wire

// ### verification/remote_serializer_model.sv
// behavioural remote serializer: lock level, link error and crc strobes
// assumes the bench sets the wanted levels shortly after a clock edge
`timescale 1ns/1ns
`default_nettype none
module remote_serializer_model (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       lock_want_in,
    input  wire logic [2:0] err_want_in,
    input  wire logic [1:0] crc_want_in,
    output logic            lock_out,
    output logic            clk_err_out,
    output logic            enc_err_out,
    output logic            par_err_out,
    output logic [1:0]      crc_err_out
);
    // outputs change at the edge, one cycle behind the wanted levels
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            {lock_out, clk_err_out, enc_err_out, par_err_out} <= 4'h0;
            crc_err_out <= 2'h0;
        end else begin
            lock_out <= lock_want_in;
            {clk_err_out, enc_err_out, par_err_out} <= err_want_in;
            crc_err_out <= crc_want_in;
        end
    end
endmodule : remote_serializer_model
`default_nettype wire

// ### verification/adaptive_eq_control_tb.sv
// self-checking bench for the adaptive equalizer control block
// assumes the serializer model drives lock and link error lines
`timescale 1ns/1ns
`default_nettype none
module adaptive_eq_control_tb;
    import aeq_pkg::*;
    logic       mclk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       aen = 1'b0;
    logic       lock_want = 1'b1;
    logic [2:0] err_want = 3'h0;
    logic [1:0] crc_want = 2'h0;
    logic [3:0] sf_lo = 4'h3;
    logic [3:0] sf_hi = 4'h4;
    logic [15:0] period = 16'h0008;
    logic [7:0] rdata;
    logic       lock, e_clk, e_enc, e_par, locked;
    logic [1:0] crc, flag;
    logic [3:0] eq, sf;
    aeq_state_t st;
    int         fails = 0;
    int         n_checks = 0;
    always #25 mclk_in = ~mclk_in;
    remote_serializer_model i_ser (.mclk_in(mclk_in), .rst_in(rst_in),
        .lock_want_in(lock_want), .err_want_in(err_want),
        .crc_want_in(crc_want), .lock_out(lock), .clk_err_out(e_clk),
        .enc_err_out(e_enc), .par_err_out(e_par), .crc_err_out(crc));
    adaptive_eq_control i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .adapt_enable_in(aen),
        .relock_timer_period_in(period), .sample_filter_lower_in(sf_lo),
        .sample_filter_upper_in(sf_hi), .lock_in(lock),
        .clk_err_in(e_clk), .enc_err_in(e_enc), .par_err_in(e_par),
        .crc_err_in(crc), .crc_err_flag_out(flag), .eq_setting_out(eq),
        .sf_setting_out(sf), .adapt_locked_out(locked),
        .adapt_state_out(st));
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #5;
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
        cmp("register read", exp, rdata);
    endtask : rd_chk
    task automatic wait_st(input aeq_state_t s);
        for (int i = 0; i < 60; i++) begin
            if (st === s) return;
            tick(1);
        end
        cmp("state wait", 8'(s), 8'(st));
        finish_test();
    endtask : wait_st
    task automatic step(input logic [3:0] xe, input logic [3:0] xs);
        logic [7:0] old;
        old = {eq, sf};
        for (int i = 0; i < 60 && {eq, sf} === old; i++) tick(1);
        cmp("next setting", {xe, xs}, {eq, sf});
        if ({eq, sf} === old) begin
            cmp("setting change", ~old, old);
            finish_test();
        end
    endtask : step
    task automatic restart(input logic [7:0] ctl, input logic [3:0] xs);
        aen = 1'b0;
        wr_reg(ADDR_CTL, ctl);
        cmp("state idle", 8'(ST_IDLE), 8'(st));
        aen = 1'b1;
        tick(1);
        cmp("start setting", {4'h0, xs}, {eq, sf});
        cmp("state wait", 8'(ST_WAIT), 8'(st));
    endtask : restart
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk_in);
        #5;
        rst_in = 1'b0;
        rd_chk(ADDR_CTL, 8'h71);
        rd_chk(ADDR_THOLD, 8'h01);
        rd_chk(ADDR_CAP, 8'h00);
        for (int a = 8'h44; a <= 8'h49; a++) begin
            wr_reg(8'(a), 8'hff);
            rd_chk(8'(a), 8'h00);
        end
        rd_chk(8'h50, 8'h00);
        wr_reg(ADDR_CTL, 8'hff);
        rd_chk(ADDR_CTL, 8'h7f);
        // paging and crc flag gating
        wr_reg(ADDR_PSEL, 8'h01);
        wr_reg(ADDR_CAP, 8'h10);
        wr_reg(ADDR_PSEL, 8'h10);
        rd_chk(ADDR_CAP, 8'h00);
        rd_chk(ADDR_PSEL, 8'h10);
        crc_want = 2'h3;
        tick(3);
        cmp("crc flag", 8'h01, {6'h0, flag});
        wr_reg(ADDR_PSEL, 8'h02);
        wr_reg(ADDR_CAP, 8'h10);
        tick(2);
        cmp("crc flag", 8'h03, {6'h0, flag});
        crc_want = 2'h0;
        wr_reg(ADDR_PSEL, 8'h00);
        rd_chk(ADDR_CAP, 8'h10);
        // single step judged on lock after half period
        restart(8'h70, 4'h7);
        tick(3);
        cmp("still waiting", 8'(ST_WAIT), 8'(st));
        tick(1);
        cmp("monitor", 8'(ST_MONITOR), 8'(st));
        cmp("locked", 8'h01, {7'h0, locked});
        period = 16'h000c;
        restart(8'h70, 4'h7);
        tick(5);
        cmp("still waiting", 8'(ST_WAIT), 8'(st));
        tick(1);
        cmp("monitor", 8'(ST_MONITOR), 8'(st));
        period = 16'h0008;
        lock_want = 1'b0;
        restart(8'h70, 4'h7);
        step(4'h1, 4'h7);
        step(4'h2, 4'h7);
        lock_want = 1'b1;
        // window count against limit, exactly equal does not move
        wr_reg(ADDR_THOLD, 8'h04);
        restart(8'h70, 4'h7);
        wait_st(ST_MONITOR);
        err_want = 3'h7;
        tick(20);
        cmp("equal count holds", 8'h07, {eq, sf});
        wr_reg(ADDR_THOLD, 8'h03);
        step(4'h1, 4'h7);
        wr_reg(ADDR_THOLD, 8'h01);
        for (int b = 0; b < 3; b++) begin
            err_want = 3'h0;
            restart({1'b0, 3'(1 << b), 4'h0}, 4'h7);
            wait_st(ST_MONITOR);
            err_want = ~3'(1 << b);
            tick(20);
            cmp("masked errors", 8'h07, {eq, sf});
            err_want = 3'(1 << b);
            step(4'h1, 4'h7);
        end
        // two step validation
        err_want = 3'h0;
        restart(8'h74, 4'h7);
        wait_st(ST_CHECK);
        tick(3);
        cmp("checking", 8'(ST_CHECK), 8'(st));
        wait_st(ST_MONITOR);
        restart(8'h74, 4'h7);
        wait_st(ST_CHECK);
        err_want = 3'h1;
        tick(3);
        cmp("two step move", 8'h17, {eq, sf});
        cmp("back to wait", 8'(ST_WAIT), 8'(st));
        err_want = 3'h0;
        // loop nesting with sample filter adaption
        lock_want = 1'b0;
        restart(8'h73, 4'h3);
        step(4'h0, 4'h4);
        step(4'h1, 4'h3);
        restart(8'h71, 4'h3);
        step(4'h1, 4'h3);
        // reset in mid-run returns defaults
        rst_in = 1'b1;
        tick(3);
        rst_in = 1'b0;
        cmp("reset setting", 8'h07, {eq, sf});
        cmp("reset state", 8'(ST_IDLE), 8'(st));
        rd_chk(ADDR_CTL, 8'h71);
        rd_chk(ADDR_CAP, 8'h00);
        finish_test();
    end
endmodule : adaptive_eq_control_tb
`default_nettype wire
